/* File: hdl/hpgc_pkg.sv */
package hpgc_pkg;

    // Register byte offsets on the bus.
    localparam logic [11:0] SEL_OFFSET   = 12'h000;
    localparam logic [11:0] DIR_OFFSET   = 12'h004;
    localparam logic [11:0] DAT_OFFSET   = 12'h008;
    localparam logic [11:0] SIRQ_OFFSET  = 12'h00c;

    // Bit positions in the pin-function select register.
    localparam int SEL_ADDR_UPPER  = 12;
    localparam int SEL_ADDR_LOWER  = 11;
    localparam int SEL_DATA_UPPER  = 8;
    localparam int SEL_DATA_LOWER  = 7;
    localparam int SEL_IRQ_PIN     = 6;
    localparam int SEL_BYTE_ID     = 4;
    localparam int SEL_ADDR_STROBE = 2;
    localparam int SEL_ACCESS_CTL  = 1;
    localparam int SEL_STROBE_GRP  = 0;

    // Bits of the select register that hold state; the rest read zero.
    localparam logic [15:0] SEL_WRITABLE = 16'h19d7;
    // Data-pin bits that exist in 8-bit multiplexed mode.
    localparam logic [15:0] LOW_BYTE_MASK = 16'h00ff;
    localparam logic [15:0] ALL_BITS_MASK = 16'hffff;

    // Reset values.
    localparam logic [15:0] SEL_RESET  = 16'h0000;
    localparam logic [15:0] DIR_RESET  = 16'h0000;
    localparam logic [15:0] DAT_RESET  = 16'h0000;
    localparam logic        SIRQ_RESET = 1'b0;

    // AHB-Lite encodings.
    localparam logic [1:0] HRESP_OKAY = 2'b00;

    // What the host port core would drive onto the pins.
    typedef struct packed {
        logic [15:0] data_out;
        logic [15:0] data_oe;
        logic        irq_out;
    } hpgc_core_drive_type;

    // Which pin groups are currently handed over to general-purpose I/O.
    typedef struct packed {
        logic addr_upper;
        logic addr_lower;
        logic data_upper;
        logic data_lower;
        logic irq_pin;
        logic byte_id;
        logic addr_strobe;
        logic access_ctl;
        logic strobe_group;
    } hpgc_pin_owner_type;

endpackage : hpgc_pkg

/* File: hdl/hpgc_top.sv */
// What this block does
// - Select register reachable by CPU bus only.
// - Bit 12 hands upper address pins to GPIO.
// - Bit 11 hands lower address pins to GPIO.
// - Bit 8 hands upper data pins to GPIO.
// - Bit 7 hands lower data pins to GPIO.
// - Bit 6 hands interrupt pin to GPIO.
// - Bit 4 hands byte-identification pin to GPIO.
// - Bit 2 hands address strobe pin to GPIO.
// - Bit 1 hands both access-control pins to GPIO.
// - Bit 0 works only while port-enable is low.
// - Address and upper-data bits need 16-bit mode.
// - Strobe and byte-id bits need 8-bit mode.
// - Reset clears select, direction and data registers.
// - Direction bit per data pin: 0 in, 1 out.
// - Input pins read level; data writes ignored.
// - Output pins drive the written data level.
// - Direction and data act only on GPIO banks.
// - Upper data-byte bits usable in 16-bit mode only.
// - GPIO address strobe can raise CPU interrupts.
module hpgc_top
    import hpgc_pkg::*;
(
    input  wire logic                clk,          // CPU clock, 250 MHz.
    input  wire logic                rstn,         // Async reset, low.
    input  wire logic                hsel,         // Slave select.
    input  wire logic [31:0]         haddr,        // Byte address.
    input  wire logic [1:0]          htrans,       // Transfer type.
    input  wire logic                hwrite,       // Write when high.
    input  wire logic [2:0]          hsize,        // Transfer size.
    input  wire logic [31:0]         hwdata,       // Write data.
    input  wire logic                hready,       // Bus ready.
    output logic      [31:0]         hrdata,       // Read data.
    output logic                     hreadyout,    // Always ready.
    output logic      [1:0]          hresp,        // Always OKAY.
    input  wire logic                mux_mode,     // High: 8-bit mux.
    input  wire logic                port_on_input,// Port-enable pin.
    input  wire hpgc_core_drive_type core_drive,   // Host port drive.
    input  wire logic [15:0]         pin_data_in,  // Data pin levels.
    input  wire logic                addr_strobe_in,// Strobe pin level.
    output logic      [15:0]         pin_data_out, // Data pin drive.
    output logic      [15:0]         pin_data_oe,  // Data pin enable.
    output logic                     pin_irq_out,  // Irq pin drive.
    output logic                     pin_irq_oe,   // Irq pin enable.
    output hpgc_pin_owner_type       pin_owner,    // GPIO ownership.
    output logic                     strobe_event  // Strobe interrupt.
);

    // Bus-side state.
    logic        dphase_wr;
    logic [11:0] dphase_addr;
    logic [15:0] pin_function_select;
    logic [15:0] data_pin_direction;
    logic [15:0] data_pin_level;
    logic        strobe_irq_enable;
    logic        strobe_prev;

    // Address phase decode; only the CPU bus reaches these registers.
    wire         addr_phase = hsel && htrans[1] && hready;
    wire         take_write = addr_phase && hwrite;
    wire         take_read  = addr_phase && !hwrite;
    wire  [11:0] rd_addr    = haddr[11:0];

    // Data phase write strobes, one per register.
    wire wr_sel  = dphase_wr && (dphase_addr == SEL_OFFSET);
    wire wr_dir  = dphase_wr && (dphase_addr == DIR_OFFSET);
    wire wr_dat  = dphase_wr && (dphase_addr == DAT_OFFSET);
    wire wr_sirq = dphase_wr && (dphase_addr == SIRQ_OFFSET);

    // Bank selects honour the bus mode of the host port.
    wire eff_addr_upper = pin_function_select[SEL_ADDR_UPPER]
                          && !mux_mode;
    wire eff_addr_lower = pin_function_select[SEL_ADDR_LOWER]
                          && !mux_mode;
    wire eff_data_upper = pin_function_select[SEL_DATA_UPPER]
                          && !mux_mode;
    wire eff_data_lower = pin_function_select[SEL_DATA_LOWER];
    wire eff_irq_pin    = pin_function_select[SEL_IRQ_PIN];
    wire eff_byte_id    = pin_function_select[SEL_BYTE_ID]
                          && mux_mode;
    wire eff_addr_strb  = pin_function_select[SEL_ADDR_STROBE]
                          && mux_mode;
    wire eff_access_ctl = pin_function_select[SEL_ACCESS_CTL];
    // A set bit 0 while the port is enabled is invalid and is ignored.
    wire eff_strobe_grp = pin_function_select[SEL_STROBE_GRP]
                          && !port_on_input;

    // Mode-dependent group enables; upper pins vanish in 8-bit mode.
    wire [15:0] exist_mask = mux_mode ? LOW_BYTE_MASK
                                      : ALL_BITS_MASK;
    wire [15:0] bank_gpio  = {{8{eff_data_upper}},
                              {8{eff_data_lower}}};

    // Direction writes keep upper bits when those pins do not exist.
    wire [15:0] dir_wmask     = exist_mask;
    wire [15:0] next_dir      = (data_pin_direction & ~dir_wmask)
                                | (hwdata[15:0] & dir_wmask);
    // Only bits of output pins take a write; inputs ignore it.
    wire [15:0] dat_wmask     = data_pin_direction & exist_mask;
    wire [15:0] next_dat      = (data_pin_level & ~dat_wmask)
                                | (hwdata[15:0] & dat_wmask);
    wire [15:0] next_sel      = hwdata[15:0] & SEL_WRITABLE;

    // Inputs show the pin, outputs show the stored drive level.
    wire [15:0] dat_view      = (data_pin_direction & data_pin_level)
                                | (~data_pin_direction
                                   & pin_data_in);

    // Pin drive: GPIO banks follow the registers, others the port core.
    wire [15:0] next_pin_out  = (bank_gpio & data_pin_level)
                                | (~bank_gpio
                                   & core_drive.data_out);
    wire [15:0] next_pin_oe   = (bank_gpio & data_pin_direction)
                                | (~bank_gpio
                                   & core_drive.data_oe);

    // A GPIO interrupt pin is released, since its own direction and
    // level controls are not part of this block.
    wire        next_irq_oe   = !eff_irq_pin;

    // Falling edge of the strobe pin while it is a GPIO interrupt source.
    wire        next_strobe_event = eff_addr_strb && strobe_irq_enable
                                    && strobe_prev
                                    && !addr_strobe_in;

    // Read mux; unmapped offsets read zero.
    logic [31:0] next_rdata;
    always_comb begin
        unique case (rd_addr)
            SEL_OFFSET:  next_rdata = {16'h0000, pin_function_select};
            DIR_OFFSET:  next_rdata = {16'h0000, data_pin_direction};
            DAT_OFFSET:  next_rdata = {16'h0000, dat_view};
            SIRQ_OFFSET: next_rdata = {31'h00000000, strobe_irq_enable};
            default:     next_rdata = 32'h00000000;
        endcase
    end

    // Zero wait states, so the slave never stretches a transfer.
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;

    // Address phase capture.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dphase_wr   <= 1'b0;
            dphase_addr <= 12'h000;
        end else if (hready) begin
            dphase_wr   <= take_write;
            dphase_addr <= haddr[11:0];
        end
    end

    // Read data is prepared at the address phase edge.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hrdata <= 32'h00000000;
        end else if (take_read) begin
            hrdata <= next_rdata;
        end
    end

    // Select register; reserved bits are never stored.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_function_select <= SEL_RESET;
        end else if (wr_sel) begin
            pin_function_select <= next_sel;
        end
    end

    // Direction register.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            data_pin_direction <= DIR_RESET;
        end else if (wr_dir) begin
            data_pin_direction <= next_dir;
        end
    end

    // Data register.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            data_pin_level <= DAT_RESET;
        end else if (wr_dat) begin
            data_pin_level <= next_dat;
        end
    end

    // Strobe interrupt enable.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strobe_irq_enable <= SIRQ_RESET;
        end else if (wr_sirq) begin
            strobe_irq_enable <= hwdata[0];
        end
    end

    // Registered pin drives keep glitches off the package pins.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_data_out <= 16'h0000;
            pin_data_oe  <= 16'h0000;
            pin_irq_out  <= 1'b0;
            pin_irq_oe   <= 1'b0;
        end else begin
            pin_data_out <= next_pin_out;
            pin_data_oe  <= next_pin_oe;
            pin_irq_out  <= core_drive.irq_out;
            pin_irq_oe   <= next_irq_oe;
        end
    end

    // Ownership flags tell the port core which pins it has lost.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_owner <= '0;
        end else begin
            pin_owner <= '{addr_upper:   eff_addr_upper,
                           addr_lower:   eff_addr_lower,
                           data_upper:   eff_data_upper,
                           data_lower:   eff_data_lower,
                           irq_pin:      eff_irq_pin,
                           byte_id:      eff_byte_id,
                           addr_strobe:  eff_addr_strb,
                           access_ctl:   eff_access_ctl,
                           strobe_group: eff_strobe_grp};
        end
    end

    // Strobe edge detect; the pin is already synchronous to clk.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strobe_prev  <= 1'b1;
            strobe_event <= 1'b0;
        end else begin
            strobe_prev  <= addr_strobe_in;
            strobe_event <= next_strobe_event;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // Register write followed by the stored value.
    sequence seq_sel_write;
        wr_sel;
    endsequence

    sequence seq_dat_write;
        wr_dat ##0 !data_pin_direction[0];
    endsequence

    sequence seq_bus_write_sel;
        take_write && (haddr[11:0] == SEL_OFFSET) ##1 1'b1;
    endsequence

    chk_sel_bus_write: assert property (
        seq_bus_write_sel |=>
            pin_function_select == ($past(hwdata[15:0]) & SEL_WRITABLE))
        else $error("select register did not take the bus write");

    chk_addr_hi_owner: assert property (
        pin_owner.addr_upper |->
            $past(pin_function_select[SEL_ADDR_UPPER] && !mux_mode))
        else $error("upper address pins owned without select in 16-bit");

    chk_addr_lo_owner: assert property (
        $past(pin_function_select[SEL_ADDR_LOWER] && !mux_mode)
            |-> pin_owner.addr_lower)
        else $error("lower address pins not handed to GPIO");

    chk_data_hi_mode: assert property (
        $past(mux_mode) |-> !pin_owner.data_upper)
        else $error("upper data pins owned in 8-bit mode");

    chk_strobe_grp_on: assert property (
        pin_owner.strobe_group |-> $past(!port_on_input))
        else $error("strobe group taken while port enabled");

    chk_addr_strb_mode: assert property (
        pin_owner.addr_strobe || pin_owner.byte_id |-> $past(mux_mode))
        else $error("strobe or byte-id owned in 16-bit mode");

    chk_input_write_kept: assert property (
        seq_dat_write |=> $stable(data_pin_level[0]))
        else $error("write changed data bit of an input pin");

    chk_output_drive: assert property (
        eff_data_lower && data_pin_direction[0] ##1
            $stable(data_pin_level[0]) |->
            pin_data_oe[0] && (pin_data_out[0] == data_pin_level[0]))
        else $error("output pin does not drive its data bit");

    chk_host_keeps_pin: assert property (
        !eff_data_lower |=>
            (pin_data_oe[0] == $past(core_drive.data_oe[0]))
            && (pin_data_out[0] == $past(core_drive.data_out[0])))
        else $error("unselected data pin left host port control");

    chk_upper_dir_kept: assert property (
        wr_dir && mux_mode |=> $stable(data_pin_direction[15:8]))
        else $error("upper direction bits written in 8-bit mode");

    chk_reset_clear: assert property (
        $rose(rstn) |-> (pin_function_select == SEL_RESET)
            && (data_pin_direction == DIR_RESET)
            && (data_pin_level == DAT_RESET))
        else $error("registers not clear after reset");

    chk_strobe_event: assert property (
        strobe_event |-> $past(eff_addr_strb && strobe_irq_enable)
            && $past(addr_strobe_in, 2) && !$past(addr_strobe_in))
        else $error("strobe event without enabled falling edge");

    chk_sel_reserved: assert property (
        seq_sel_write |=> (pin_function_select & ~SEL_WRITABLE) == 16'h0000)
        else $error("reserved select bits were stored");

    // Each pin group's ownership follows its own select bit and mode.
    chk_data_hi_owner: assert property (
        pin_owner.data_upper
            == $past(pin_function_select[SEL_DATA_UPPER] && !mux_mode))
        else $error("upper data pins do not follow their select bit");

    chk_data_lo_owner: assert property (
        pin_owner.data_lower == $past(pin_function_select[SEL_DATA_LOWER]))
        else $error("lower data pins do not follow their select bit");

    chk_irq_pin_release: assert property (
        $past(rstn) |->
            pin_irq_oe == !$past(pin_function_select[SEL_IRQ_PIN]))
        else $error("interrupt pin drive does not follow its select bit");

    chk_byte_id_owner: assert property (
        pin_owner.byte_id
            == $past(pin_function_select[SEL_BYTE_ID] && mux_mode))
        else $error("byte-id pin ownership does not follow its select bit");

    chk_strb_owner: assert property (
        pin_owner.addr_strobe
            == $past(pin_function_select[SEL_ADDR_STROBE] && mux_mode))
        else $error("strobe pin ownership does not follow its select bit");

    chk_access_owner: assert property (
        pin_owner.access_ctl == $past(pin_function_select[SEL_ACCESS_CTL]))
        else $error("access-control pins do not follow their select bit");

    chk_addr_mux_off: assert property (
        $past(mux_mode) |-> !pin_owner.addr_upper && !pin_owner.addr_lower)
        else $error("address pins owned in 8-bit mode");

    // Registered pin drives lag the registers by one cycle, and the cycle
    // right after reset still shows the reset drive, so it is skipped.
    chk_dir_sets_oe: assert property (
        $past(rstn && eff_data_lower) |->
            pin_data_oe[7:0] == $past(data_pin_direction[7:0]))
        else $error("lower data pin enables do not follow direction");

    chk_upper_host: assert property (
        $past(rstn && !eff_data_upper) |->
            pin_data_oe[15:8] == $past(core_drive.data_oe[15:8]))
        else $error("upper data pins left host port control");

    chk_upper_gpio: assert property (
        $past(rstn && eff_data_upper) |->
            pin_data_out[15:8] == $past(data_pin_level[15:8]))
        else $error("upper data pins do not drive their data bits");

    chk_input_read: assert property (
        take_read && (haddr[11:0] == DAT_OFFSET) && !data_pin_direction[2]
            |=> hrdata[2] == $past(pin_data_in[2]))
        else $error("input pin read does not show the pin level");

    chk_output_write: assert property (
        wr_dat && data_pin_direction[5] |=>
            data_pin_level[5] == $past(hwdata[5]))
        else $error("output pin data bit did not take the write");

endmodule : hpgc_top

/* File: testbench/test_hpgc_top.sv */
module test_hpgc_top
    import hpgc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic                clk;
    logic                rstn;
    logic                hsel;
    logic [31:0]         haddr;
    logic [1:0]          htrans;
    logic                hwrite;
    logic [2:0]          hsize;
    logic [31:0]         hwdata;
    logic                hready;
    logic [31:0]         hrdata;
    logic                hreadyout;
    logic [1:0]          hresp;
    logic                mux_mode;
    logic                port_on_input;
    hpgc_core_drive_type core_drive;
    logic [15:0]         pin_data_in;
    logic                addr_strobe_in;
    logic [15:0]         pin_data_out;
    logic [15:0]         pin_data_oe;
    logic                pin_irq_out;
    logic                pin_irq_oe;
    hpgc_pin_owner_type  pin_owner;
    logic                strobe_event;
    int                  n_fail;
    int                  checked;
    int                  cycles;
    logic [31:0]         rd;
    logic [15:0]         sels [10];

    // The single slave's ready is the bus ready.
    assign hready = hreadyout;

    hpgc_top u_hpgc_top (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .mux_mode(mux_mode), .port_on_input(port_on_input),
        .core_drive(core_drive), .pin_data_in(pin_data_in),
        .addr_strobe_in(addr_strobe_in), .pin_data_out(pin_data_out),
        .pin_data_oe(pin_data_oe), .pin_irq_out(pin_irq_out),
        .pin_irq_oe(pin_irq_oe), .pin_owner(pin_owner),
        .strobe_event(strobe_event));

    // Free-running 250 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Hang guard; the tests need well under a thousand cycles.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // One single-word transfer; entered right after a rising edge.
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {20'h00000, a};
        hsize  <= 3'b010;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        r = hrdata;
    endtask : bus

    // Expected ownership, worked out from select bits, mode and port pin.
    function automatic hpgc_pin_owner_type exp_owner(input logic [15:0] s,
                                                     input logic m,
                                                     input logic p);
        hpgc_pin_owner_type o;
        o.addr_upper   = s[12] & !m;
        o.addr_lower   = s[11] & !m;
        o.data_upper   = s[8] & !m;
        o.data_lower   = s[7];
        o.irq_pin      = s[6];
        o.byte_id      = s[4] & m;
        o.addr_strobe  = s[2] & m;
        o.access_ctl   = s[1];
        o.strobe_group = s[0] & !p;
        return o;
    endfunction : exp_owner

    // Registers start at zero and every pin belongs to the host port.
    task automatic test_reset();
        bus(1'b0, SEL_OFFSET, 32'h0, rd);
        check("sel", rd, 32'h0);
        check("hresp", {30'h0, hresp}, 32'h0);
        check("hready", {31'h0, hreadyout}, 32'h1);
        bus(1'b0, DIR_OFFSET, 32'h0, rd);
        check("dir", rd, 32'h0);
        bus(1'b0, DAT_OFFSET, 32'h0, rd);
        check("dat", rd, 32'h0);
        check("owner", {23'h0, pin_owner}, 32'h0);
        check("out", {16'h0, pin_data_out}, 32'h1234);
        check("oe", {16'h0, pin_data_oe}, 32'h5678);
        check("irq_oe", {31'h0, pin_irq_oe}, 32'h1);
        $display("test_reset done");
    endtask : test_reset

    // Each select bit alone and all ones, in both modes; the port pin follows bit 0 of the pattern index.
    task automatic test_select();
        for (int m = 0; m < 2; m++) begin
            for (int k = 0; k < 10; k++) begin
                mux_mode      <= m[0];
                port_on_input <= k[0];
                bus(1'b1, SEL_OFFSET, {16'h0, sels[k]}, rd);
                tick(3);
                check("owner",
                    {23'h0, pin_owner},
                    {23'h0, exp_owner(sels[k], m[0], k[0])});
                check("irq_oe", {31'h0, pin_irq_oe},
                    {31'h0, !sels[k][6]});
                check("irq_out", {31'h0, pin_irq_out}, 32'h1);
                bus(1'b0, SEL_OFFSET, 32'h0, rd);
                check("sel", rd, {16'h0, sels[k] & 16'h19d7});
            end
        end
        $display("test_select done");
    endtask : test_select

    // Data pins as GPIO: direction, drive, sampling and bank split.
    task automatic test_data();
        mux_mode    <= 1'b0;
        pin_data_in <= 16'h3c3c;
        bus(1'b1, SEL_OFFSET, 32'h0180, rd);
        bus(1'b1, DIR_OFFSET, 32'hf0f0, rd);
        bus(1'b1, DAT_OFFSET, 32'ha5a5, rd);
        tick(2);
        check("oe", {16'h0, pin_data_oe}, 32'hf0f0);
        check("out", {16'h0, pin_data_out & 16'hf0f0}, 32'ha0a0);
        bus(1'b0, DAT_OFFSET, 32'h0, rd);
        check("dat", rd & 32'hffff, 32'hacac);
        bus(1'b1, DIR_OFFSET, 32'hffff, rd);
        tick(2);
        check("out", {16'h0, pin_data_out}, 32'ha0a0);
        bus(1'b1, SEL_OFFSET, 32'h0080, rd);
        tick(2);
        check("out", {16'h0, pin_data_out}, 32'h12a0);
        check("oe", {16'h0, pin_data_oe}, 32'h56ff);
        bus(1'b1, SEL_OFFSET, 32'h0180, rd);
        mux_mode <= 1'b1;
        tick(3);
        check("oe", {16'h0, pin_data_oe}, 32'h56ff);
        bus(1'b1, DIR_OFFSET, 32'h0000, rd);
        bus(1'b0, DIR_OFFSET, 32'h0, rd);
        check("dir", rd & 32'hffff, 32'hff00);
        $display("test_data done");
    endtask : test_data

    // Count strobe pulses around one falling edge of the strobe pin.
    task automatic strobe_pulses(output int n);
        n = 0;
        addr_strobe_in <= 1'b1;
        tick(3);
        addr_strobe_in <= 1'b0;
        repeat (8) begin
            @(posedge clk);
            if (strobe_event === 1'b1) n = n + 1;
        end
    endtask : strobe_pulses

    // Strobe interrupt, unmapped space and a reset in mid-run.
    task automatic test_misc();
        int n;
        bus(1'b1, SEL_OFFSET, 32'h0004, rd);
        bus(1'b1, SIRQ_OFFSET, 32'h1, rd);
        bus(1'b0, SIRQ_OFFSET, 32'h0, rd);
        check("sirq", rd, 32'h1);
        strobe_pulses(n);
        check("pulses", n, 1);
        mux_mode <= 1'b0;
        strobe_pulses(n);
        check("pulses", n, 0);
        bus(1'b1, 12'h010, 32'hffff, rd);
        bus(1'b0, 12'h010, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        bus(1'b0, SEL_OFFSET, 32'h0, rd);
        check("sel", rd, 32'h0004);
        rstn <= 1'b0;
        tick(2);
        rstn <= 1'b1;
        tick(1);
        bus(1'b0, SEL_OFFSET, 32'h0, rd);
        check("sel", rd, 32'h0);
        bus(1'b0, DIR_OFFSET, 32'h0, rd);
        check("dir", rd, 32'h0);
        check("owner", {23'h0, pin_owner}, 32'h0);
        $display("test_misc done");
    endtask : test_misc

    // Main sequence: reset for three cycles, then the tests in turn.
    initial begin
        sels = '{16'h1000, 16'h0800, 16'h0100, 16'h0080, 16'h0040,
                 16'h0010, 16'h0004, 16'h0002, 16'h0001, 16'hffff};
        n_fail = 0;
        checked = 0;
        cycles = 0;
        rstn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        mux_mode = 1'b0;
        port_on_input = 1'b1;
        core_drive = '{data_out: 16'h1234, data_oe: 16'h5678, irq_out: 1'b1};
        pin_data_in = 16'h0;
        addr_strobe_in = 1'b1;
        tick(3);
        rstn <= 1'b1;
        tick(2);
        test_reset();
        test_select();
        test_data();
        test_misc();
        final_report();
    end
endmodule : test_hpgc_top
